// ==== logic/pidlc_core.sv ====
// Our own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pidlc_regs.svh"
module pidlc_core
  import pidlc_pkg::*;
#(
  parameter int PER_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sample_tick,
  input wire pidlc_q_t measured_value,
  input wire pidlc_q_t cascade_target,
  output pidlc_q_t control_out,
  output logic out_valid,
  output pidlc_alarm_t alarms
);

  if (PER_W < 14 || PER_W > 16) begin : g_chk
    $error("PER_W must lie in 14..16");
  end

  localparam logic [31:0] PER_MASK = (32'h1 << PER_W) - 32'h1;

  // ==========================================================
  // arithmetic helpers
  function automatic pidlc_q_t qmul(input pidlc_q_t a,
                                    input pidlc_q_t b);
    logic signed [63:0] p;
    p = 64'(a) * 64'(b);
    return p[`PIDLC_FRAC +: 32];
  endfunction : qmul

  function automatic pidlc_q_t qabs(input pidlc_q_t a);
    return a[31] ? -a : a;
  endfunction : qabs

  function automatic pidlc_q_t clamp01(input pidlc_q_t a);
    if (a < 32'sh0) return '0;
    if (a > `PIDLC_ONE) return `PIDLC_ONE;
    return a;
  endfunction : clamp01

  // set wins over clear; clear needs the full hysteresis margin
  function automatic logic alarm_up(input logic act,
                                    input pidlc_q_t v,
                                    input pidlc_q_t thr,
                                    input pidlc_q_t hy);
    if (v > thr) return 1'b1;
    if (v <= thr - hy) return 1'b0;
    return act;
  endfunction : alarm_up

  function automatic pidlc_q_t qsqrt(input pidlc_q_t x);
    logic [47:0] v;
    logic [47:0] r;
    logic [47:0] b;
    v = x[31] ? '0 : 48'(x) << `PIDLC_FRAC;
    r = '0;
    b = 48'h400000000000;
    for (int i = 0; i < `PIDLC_SQRT_STEPS; i++) begin
      if (v >= r + b) begin
        v = v - r - b;
        r = (r >> 1) + b;
      end else begin
        r = r >> 1;
      end
      b = b >> 2;
    end
    return pidlc_q_t'(r[31:0]);
  endfunction : qsqrt

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction : merge

  // divide by zero gives zero, overflow saturates
  function automatic pidlc_q_t sat_quo(input logic [47:0] q,
                                       input logic [31:0] d);
    if (d == '0) return '0;
    if (|q[47:31]) return `PIDLC_QMAX;
    return pidlc_q_t'(q[31:0]);
  endfunction : sat_quo

  // ==========================================================
  // register file
  logic [31:0] cfg_q [`PIDLC_NCFG];
  logic [31:0] dat_q;
  logic [31:0] rd_mux;
  logic ack_q;
  logic wb_req;
  logic wb_wr;
  logic [3:0] wb_ix;
  pidlc_ctrl_t ctrl;
  pidlc_q_t target_q;
  pidlc_q_t bias_q;
  pidlc_q_t out_q;
  logic valid_q;
  pidlc_alarm_t alarm_q;
  pidlc_state_t st_q;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wb_wr = wb_req & wb_we_i;
  assign wb_ix = wb_adr_i[5:2];
  assign ctrl = pidlc_ctrl_t'(cfg_q[`PIDLC_IX_CTRL]);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= wb_req;
      if (wb_req) dat_q <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = '0;
    if (wb_adr_i < `PIDLC_OFS_TARGET) begin
      rd_mux = cfg_q[wb_ix];
    end else begin
      case ({wb_adr_i[7:2], 2'h0})
        `PIDLC_OFS_TARGET: rd_mux = target_q;
        `PIDLC_OFS_BIAS: rd_mux = bias_q;
        `PIDLC_OFS_STATUS: rd_mux = 32'({st_q != ST_IDLE, alarm_q});
        `PIDLC_OFS_OUTPUT: rd_mux = out_q;
        default: rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `PIDLC_NCFG; i++) cfg_q[i] <= `PIDLC_CFG_RST;
    end else if (wb_wr && wb_adr_i < `PIDLC_OFS_TARGET) begin
      cfg_q[wb_ix] <= merge(cfg_q[wb_ix], wb_dat_i, wb_sel_i) &
        (wb_ix == `PIDLC_IX_CTRL ? `PIDLC_CTRL_MASK : 32'hffffffff);
    end
  end

  // ==========================================================
  // configuration views
  logic [31:0] ts, ti, td, kd, tskd;
  pidlc_q_t c_kc, c_man, c_db, c_hy;
  logic auto_md;
  logic ti_off;
  assign ts = cfg_q[`PIDLC_IX_TS] & PER_MASK;
  assign ti = cfg_q[`PIDLC_IX_TI] & PER_MASK;
  assign td = cfg_q[`PIDLC_IX_TD] & PER_MASK;
  assign kd = cfg_q[`PIDLC_IX_KD] & `PIDLC_KD_MASK;
  assign tskd = ts * kd;
  assign c_kc = cfg_q[`PIDLC_IX_GAIN];
  assign c_man = cfg_q[`PIDLC_IX_MAN];
  assign c_db = cfg_q[`PIDLC_IX_DBAND];
  assign c_hy = cfg_q[`PIDLC_IX_HYST];
  // illegal mode code falls back to manual
  assign auto_md = ctrl.mode == `PIDLC_MODE_AUTO ||
                   ctrl.mode == `PIDLC_MODE_CASC;
  assign ti_off = ti == `PIDLC_NO_RESET;

  // ==========================================================
  // sample capture and sequencing
  logic [1:0] idx_q;
  logic [5:0] cnt_q;
  logic [47:0] num_q, quo_q, quo_nx;
  logic [31:0] rem_q, den_q, op_n, op_d;
  logic [32:0] rem_sh, rem_nx;
  logic quo_bit;
  logic div_last;
  pidlc_q_t pv_q, sp_q, sp1_q, pv1_q, pv2_q, e1_q, y1_q, y2_q;
  pidlc_q_t kib_q, krb_q, fg_q, ratio_q;
  logic ratio_ok_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pv_q <= '0;
      sp_q <= '0;
    end else if (st_q == ST_IDLE && sample_tick) begin
      pv_q <= ctrl.sqroot ? qsqrt(measured_value)
                          : measured_value;
      sp_q <= ctrl.mode == `PIDLC_MODE_CASC ? cascade_target
                                            : target_q;
    end
  end

  // one shared divider: reset ratio, rate ratio, filter gain, step
  always_comb begin
    unique case (idx_q)
      2'h0: begin
        op_n = ts;
        op_d = ti;
      end
      2'h1: begin
        op_n = td;
        op_d = ts;
      end
      2'h2: begin
        op_n = tskd;
        op_d = tskd + td;
      end
      2'h3: begin
        op_n = ctrl.reverse ? sp1_q : sp_q;
        op_d = ctrl.reverse ? sp_q : sp1_q;
      end
    endcase
  end

  assign rem_sh = {rem_q, num_q[47]};
  assign quo_bit = rem_sh >= {1'b0, den_q};
  assign rem_nx = quo_bit ? rem_sh - {1'b0, den_q} : rem_sh;
  assign quo_nx = {quo_q[46:0], quo_bit};
  assign div_last = st_q == ST_DIV && cnt_q == `PIDLC_DIV_STEPS;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= ST_IDLE;
      idx_q <= '0;
      cnt_q <= '0;
      num_q <= '0;
      den_q <= '0;
      rem_q <= '0;
      quo_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (sample_tick) begin
            st_q <= ST_DIV;
            idx_q <= '0;
            cnt_q <= '0;
          end
        end
        ST_DIV: begin
          if (cnt_q == '0) begin
            num_q <= 48'(op_n) << `PIDLC_FRAC;
            den_q <= op_d;
            rem_q <= '0;
            quo_q <= '0;
            cnt_q <= cnt_q + 6'h1;
          end else if (div_last) begin
            cnt_q <= '0;
            idx_q <= idx_q + 2'h1;
            if (idx_q == 2'h3) st_q <= ST_CALC;
          end else begin
            num_q <= {num_q[46:0], 1'b0};
            rem_q <= rem_nx[31:0];
            quo_q <= quo_nx;
            cnt_q <= cnt_q + 6'h1;
          end
        end
        ST_CALC: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      kib_q <= '0;
      krb_q <= '0;
      fg_q <= '0;
      ratio_q <= '0;
      ratio_ok_q <= 1'b0;
    end else if (div_last) begin
      // the last quotient bit is only formed combinationally at this edge
      unique case (idx_q)
        2'h0: kib_q <= sat_quo(quo_nx, den_q);
        2'h1: krb_q <= sat_quo(quo_nx, den_q);
        2'h2: fg_q <= sat_quo(quo_nx, den_q);
        2'h3: begin
          ratio_q <= sat_quo(quo_nx, den_q);
          ratio_ok_q <= den_q != '0;
        end
      endcase
    end
  end

  // ==========================================================
  // loop equation
  pidlc_q_t ki, kr, diff, e, y, d1, d2, bias0;
  pidlc_q_t pt, it, dt, bacc, dv, mraw, mcl, bnew;
  logic sat;
  logic prev_auto_q;
  logic xfer;
  assign xfer = auto_md && !prev_auto_q && !ctrl.velocity;

  always_comb begin
    ki = ti_off ? '0 : (c_kc != '0 ? qmul(c_kc, kib_q) : kib_q);
    kr = td == '0 ? '0 : (c_kc != '0 ? qmul(c_kc, krb_q) : krb_q);
    diff = sp_q - pv_q;
    e = ctrl.esq ? qmul(diff, qabs(diff)) : diff;
    if (ctrl.dband && qabs(e) < c_db) e = '0;
    y = ctrl.dlim ? y1_q + qmul(fg_q, pv_q - y1_q) : pv_q;
    d1 = ctrl.dlim ? y - y1_q : pv_q - pv1_q;
    d2 = ctrl.dlim ? y - (y1_q <<< 1) + y2_q
                   : pv_q - (pv1_q <<< 1) + pv2_q;
    bias0 = bias_q;
    if (!ctrl.freeze && !ctrl.velocity && sp_q != sp1_q && ratio_ok_q) begin
      bias0 = clamp01(qmul(bias_q, ratio_q));
    end
    pt = qmul(c_kc, e);
    it = qmul(ki, e);
    dt = qmul(kr, d1);
    if (ctrl.dlim) begin
      dv = qmul(c_kc, e - e1_q) + it - qmul(kr, d2);
    end else begin
      dv = qmul(c_kc, e - e1_q) + qmul(ki, d2);
    end
    if (ctrl.reverse) begin
      pt = -pt;
      it = -it;
      dt = -dt;
      dv = -dv;
    end
    bacc = clamp01(bias0 + it);
    mraw = ctrl.velocity ? out_q + dv : pt - dt + bacc;
    mcl = clamp01(mraw);
    sat = mraw != mcl;
    bnew = bacc;
    if (ctrl.velocity || ti_off && sat) begin
      bnew = bias0;
    end else if (sat && ctrl.freeze) begin
      bnew = bias_q;
    end else if (sat) begin
      bnew = clamp01(mcl - pt + dt);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= '0;
      valid_q <= 1'b0;
      prev_auto_q <= 1'b0;
    end else begin
      valid_q <= st_q == ST_CALC;
      if (st_q == ST_CALC) begin
        prev_auto_q <= auto_md;
        if (!auto_md) out_q <= c_man;
        else if (!xfer) out_q <= mcl;
      end
    end
  end

  // a software write racing the update loses to the loop
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      bias_q <= '0;
    end else if (st_q == ST_CALC && auto_md) begin
      bias_q <= xfer ? out_q : bnew;
    end else if (wb_wr && {wb_adr_i[7:2], 2'h0} == `PIDLC_OFS_BIAS) begin
      bias_q <= merge(bias_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      target_q <= '0;
    end else if (st_q == ST_CALC && xfer && !ctrl.smooth2) begin
      target_q <= pv_q;
    end else if (wb_wr && {wb_adr_i[7:2], 2'h0} == `PIDLC_OFS_TARGET) begin
      target_q <= merge(target_q, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      e1_q <= '0;
      pv1_q <= '0;
      pv2_q <= '0;
      y1_q <= '0;
      y2_q <= '0;
      sp1_q <= '0;
    end else if (st_q == ST_CALC) begin
      e1_q <= e;
      pv1_q <= pv_q;
      pv2_q <= pv1_q;
      y1_q <= y;
      y2_q <= y1_q;
      // a transfer without smooth2 reloads the target, so the next step is measured from it
      sp1_q <= xfer && !ctrl.smooth2 ? pv_q : sp_q;
    end
  end

  // ==========================================================
  // alarms, evaluated in every mode
  pidlc_q_t dev;
  assign dev = pv_q - sp_q;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_q <= '0;
    end else if (st_q == ST_CALC) begin
      alarm_q.hi_hi <= alarm_up(alarm_q.hi_hi, pv_q,
        cfg_q[`PIDLC_IX_HH], c_hy);
      alarm_q.hi <= alarm_up(alarm_q.hi, pv_q,
        cfg_q[`PIDLC_IX_HI], c_hy);
      alarm_q.lo <= alarm_up(alarm_q.lo, -pv_q,
        -cfg_q[`PIDLC_IX_LO], c_hy);
      alarm_q.lo_lo <= alarm_up(alarm_q.lo_lo, -pv_q,
        -cfg_q[`PIDLC_IX_LL], c_hy);
      alarm_q.dev_in_hi <= alarm_up(alarm_q.dev_in_hi, dev,
        cfg_q[`PIDLC_IX_YDEV], c_hy);
      alarm_q.dev_in_lo <= alarm_up(alarm_q.dev_in_lo, -dev,
        cfg_q[`PIDLC_IX_YDEV], c_hy);
      alarm_q.dev_out_hi <= alarm_up(alarm_q.dev_out_hi, dev,
        cfg_q[`PIDLC_IX_ODEV], c_hy);
      alarm_q.dev_out_lo <= alarm_up(alarm_q.dev_out_lo, -dev,
        cfg_q[`PIDLC_IX_ODEV], c_hy);
      alarm_q.roc <= qabs(pv_q - pv1_q) >
        pidlc_q_t'(cfg_q[`PIDLC_IX_RLIM]);
    end
  end

  assign control_out = out_q;
  assign out_valid = valid_q;
  assign alarms = alarm_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing wrong");
  property p_lat;
    st_q == ST_IDLE && sample_tick |-> ##197 !out_valid ##1 out_valid;
  endproperty
  a_lat: assert property (p_lat) else $error("latency wrong");
  property p_clamp;
    st_q == ST_CALC && auto_md && !xfer |=>
      control_out >= 32'sh0 && control_out <= `PIDLC_ONE;
  endproperty
  a_clamp: assert property (p_clamp) else $error("no clamp");
  property p_man;
    st_q == ST_CALC && !auto_md |=> control_out == $past(c_man);
  endproperty
  a_man: assert property (p_man) else $error("manual out");
  property p_frz;
    st_q == ST_CALC && auto_md && !xfer && sat && ctrl.freeze &&
      !ctrl.velocity |=> $stable(bias_q);
  endproperty
  a_frz: assert property (p_frz) else $error("bias moved");
  property p_xfer;
    st_q == ST_CALC && xfer && !ctrl.smooth2 |=>
      target_q == $past(pv_q) && bias_q == $past(out_q) &&
      $stable(control_out);
  endproperty
  a_xfer: assert property (p_xfer) else $error("bumped");
  property p_hhs;
    $rose(alarms.hi_hi) |->
      $past(pv_q) > pidlc_q_t'($past(cfg_q[`PIDLC_IX_HH]));
  endproperty
  a_hhs: assert property (p_hhs) else $error("hh early");
  property p_hhc;
    $fell(alarms.hi_hi) |->
      $past(pv_q) <= pidlc_q_t'($past(cfg_q[`PIDLC_IX_HH])) - $past(c_hy);
  endproperty
  a_hhc: assert property (p_hhc) else $error("hh cleared");
  property p_dev;
    $rose(alarms.dev_in_hi) |->
      $past(dev) > pidlc_q_t'($past(cfg_q[`PIDLC_IX_YDEV]));
  endproperty
  a_dev: assert property (p_dev) else $error("dev early");
  property p_roc;
    out_valid |-> alarms.roc ==
      (qabs(pv1_q - pv2_q) > pidlc_q_t'(cfg_q[`PIDLC_IX_RLIM]));
  endproperty
  a_roc: assert property (p_roc) else $error("rate alarm");
  property p_chg;
    $changed(control_out) |-> out_valid;
  endproperty
  a_chg: assert property (p_chg) else $error("stray out");

  c_sat: cover property (st_q == ST_CALC && auto_md && sat);
  c_xfer: cover property (st_q == ST_CALC && xfer);
  c_step: cover property (st_q == ST_CALC && sp_q != sp1_q && ratio_ok_q);
  c_vel: cover property (st_q == ST_CALC && auto_md && ctrl.velocity);

endmodule : pidlc_core
`default_nettype wire

// ==== logic/pidlc_regs.svh ====
`ifndef PIDLC_REGS_SVH
`define PIDLC_REGS_SVH
`define PIDLC_FRAC 16
`define PIDLC_ONE 32'sh00010000
`define PIDLC_QMAX 32'sh7fffffff
`define PIDLC_NCFG 16
`define PIDLC_IX_CTRL 4'h0
`define PIDLC_IX_GAIN 4'h1
`define PIDLC_IX_TS 4'h2
`define PIDLC_IX_TI 4'h3
`define PIDLC_IX_TD 4'h4
`define PIDLC_IX_KD 4'h5
`define PIDLC_IX_MAN 4'h6
`define PIDLC_IX_DBAND 4'h7
`define PIDLC_IX_HH 4'h8
`define PIDLC_IX_HI 4'h9
`define PIDLC_IX_LO 4'ha
`define PIDLC_IX_LL 4'hb
`define PIDLC_IX_YDEV 4'hc
`define PIDLC_IX_ODEV 4'hd
`define PIDLC_IX_RLIM 4'he
`define PIDLC_IX_HYST 4'hf
`define PIDLC_OFS_TARGET 8'h40
`define PIDLC_OFS_BIAS 8'h44
`define PIDLC_OFS_STATUS 8'h48
`define PIDLC_OFS_OUTPUT 8'h4c
`define PIDLC_CFG_RST 32'h00000000
`define PIDLC_CTRL_MASK 32'h000003ff
`define PIDLC_KD_MASK 32'h000000ff
`define PIDLC_NO_RESET 32'h0000270f
`define PIDLC_MODE_MAN 2'h0
`define PIDLC_MODE_AUTO 2'h1
`define PIDLC_MODE_CASC 2'h2
`define PIDLC_DIV_STEPS 6'h30
`define PIDLC_SQRT_STEPS 24
`endif

// ==== logic/pidlc_pkg.sv ====
package pidlc_pkg;
  typedef logic signed [31:0] pidlc_q_t;
  typedef struct packed {
    logic [21:0] rsvd;
    logic smooth2;
    logic dlim;
    logic dband;
    logic esq;
    logic sqroot;
    logic freeze;
    logic reverse;
    logic velocity;
    logic [1:0] mode;
  } pidlc_ctrl_t;
  typedef struct packed {
    logic roc;
    logic dev_out_lo;
    logic dev_out_hi;
    logic dev_in_lo;
    logic dev_in_hi;
    logic lo_lo;
    logic lo;
    logic hi;
    logic hi_hi;
  } pidlc_alarm_t;
  typedef enum logic [1:0] {ST_IDLE, ST_DIV, ST_CALC} pidlc_state_t;
endpackage : pidlc_pkg

// ==== tb/pidlc_analog_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// analog channel stand-in
module pidlc_analog_model
  import pidlc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic out_valid,
  input wire pidlc_q_t control_out,
  output pidlc_q_t measured_value,
  output pidlc_q_t actuator_q
);
  pidlc_q_t level_q = '0;
  assign measured_value = level_q;
  // the actuator only moves on a fresh output, never on a stale one
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      actuator_q <= '0;
    end else if (out_valid) begin
      actuator_q <= control_out;
    end
  end
  task automatic set_level(input pidlc_q_t v);
    level_q <= v;
  endtask : set_level
endmodule : pidlc_analog_model
`default_nettype wire

// ==== tb/pid_loop_calculator_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module pid_loop_calculator_tb
  import pidlc_pkg::*;
;
  logic sys_clk, nrst, cyc, stb, we, tick, ack, ovalid;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, ack_dat;
  pidlc_q_t pv, casc, cout, act;
  pidlc_alarm_t alarms;
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  // ctrl, gain, periods, filter, manual out, deadband, limits, hysteresis
  logic [31:0] cfg [16] = '{32'h0, 32'h10000, 32'h1, 32'h1, 32'h0, 32'h0,
    32'h20000, 32'h0, 32'h30000, 32'h10000, 32'hffff0000, 32'hfffe0000,
    32'h7fff0000, 32'h7fff0000, 32'h7fff0000, 32'h1000};

  pidlc_core u_dut (.sys_clk(sys_clk), .nrst(nrst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(ack_dat), .wb_ack_o(ack),
    .sample_tick(tick), .measured_value(pv), .cascade_target(casc),
    .control_out(cout), .out_valid(ovalid), .alarms(alarms));
  pidlc_analog_model u_ana (.sys_clk(sys_clk), .nrst(nrst),
    .out_valid(ovalid), .control_out(cout), .measured_value(pv),
    .actuator_q(act));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input string what, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rdat = ack_dat;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk("register", e, rdat);
  endtask : rchk

  task automatic sample(input pidlc_q_t v, input logic [31:0] eo);
    int n;
    n = 0;
    u_ana.set_level(v);
    @(posedge sys_clk);
    tick <= 1'b1;
    @(posedge sys_clk);
    tick <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ovalid !== 1'b1 && n < 400);
    if (n >= 400) chk("valid", 32'h1, 32'h0);
    @(posedge sys_clk);
    chk("output", eo, act);
  endtask : sample

  task automatic achk(input logic [8:0] e);
    chk("alarms", {23'h0, e}, {23'h0, alarms});
  endtask : achk

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    nrst = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'hf;
    wdat = 32'h0;
    tick = 1'b0;
    casc = 32'sh0;
    repeat (6) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) rchk(8'(8'h40 + 4 * i), 32'h0);
    wb(1'b1, 8'h50, 32'h1234);
    rchk(8'h50, 32'h0);
    for (int i = 0; i < 16; i++) wb(1'b1, 8'(4 * i), cfg[i]);
    $display("reset and map test done");
    sample(32'sh18000, 32'h20000);
    achk(9'h002);
    rchk(8'h48, 32'h2);
    sample(32'shf800, 32'h20000);
    achk(9'h002);
    sample(32'she000, 32'h20000);
    achk(9'h000);
    sample(32'shfffd0000, 32'h20000);
    achk(9'h00c);
    wb(1'b1, 8'h38, 32'h10000);
    sample(32'sh0, 32'h20000);
    achk(9'h100);
    wb(1'b1, 8'h38, 32'h7fff0000);
    wb(1'b1, 8'h30, 32'h8000);
    sample(32'sh9000, 32'h20000);
    achk(9'h010);
    $display("alarm test done");
    wb(1'b1, 8'h18, 32'h8000);
    sample(32'sh4000, 32'h8000);
    wb(1'b1, 8'h00, 32'h1);
    sample(32'sh4000, 32'h8000);
    rchk(8'h40, 32'h4000);
    rchk(8'h44, 32'h8000);
    wb(1'b1, 8'h40, 32'h2000);
    sample(32'sh2000, 32'h4000);
    rchk(8'h44, 32'h4000);
    wb(1'b1, 8'h0c, 32'h270f);
    sample(32'sh1000, 32'h5000);
    rchk(8'h44, 32'h4000);
    wb(1'b1, 8'h0c, 32'h1);
    sample(32'sh1000, 32'h6000);
    rchk(8'h44, 32'h5000);
    wb(1'b1, 8'h00, 32'h11);
    sample(32'shffff0000, 32'h10000);
    rchk(8'h44, 32'h5000);
    wb(1'b1, 8'h00, 32'h1);
    sample(32'shffff0000, 32'h10000);
    rchk(8'h44, 32'h0);
    wb(1'b1, 8'h0c, 32'h270f);
    wb(1'b1, 8'h44, 32'h8000);
    wb(1'b1, 8'h00, 32'h9);
    sample(32'sh1000, 32'h7000);
    wb(1'b1, 8'h00, 32'h41);
    sample(32'sh1000, 32'h8100);
    wb(1'b1, 8'h1c, 32'h200);
    wb(1'b1, 8'h00, 32'hc1);
    sample(32'sh1000, 32'h8000);
    wb(1'b1, 8'h00, 32'h21);
    sample(32'sh400, 32'h8000);
    casc <= 32'sh3000;
    wb(1'b1, 8'h00, 32'h2);
    sample(32'sh3000, 32'hc000);
    rchk(8'h44, 32'hc000);
    wb(1'b1, 8'h0c, 32'h1);
    wb(1'b1, 8'h00, 32'h5);
    sample(32'sh5000, 32'ha000);
    wb(1'b1, 8'h00, 32'h0);
    sample(32'sh38000, 32'h8000);
    achk(9'h013);
    wb(1'b1, 8'h00, 32'h201);
    sample(32'sh1000, 32'h8000);
    rchk(8'h40, 32'h2000);
    rchk(8'h44, 32'h8000);
    $display("automatic test done");
    conclude();
  end
endmodule : pid_loop_calculator_tb
`default_nettype wire
